/* rtl/ncp_pkg.sv */
// Purpose: Shared constants for the oscillator phase register bank
// Assumes: 32-bit AHB-Lite data bus, one register per aligned word
// Notes:   Byte registers sit in the low bits of each word, upper bits read zero

package ncp_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int NCP_ACC_W = 20;
  localparam int NCP_AW = 8;
  localparam int NCP_UPPER_W = 4;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] NCP_OFS_ACC_LOW = 8'h00;
  localparam logic [7:0] NCP_OFS_ACC_HIGH = 8'h04;
  localparam logic [7:0] NCP_OFS_ACC_UPPER = 8'h08;
  localparam logic [7:0] NCP_OFS_STEP_LOW = 8'h0C;
  localparam logic [7:0] NCP_OFS_STEP_HIGH = 8'h10;
  localparam logic [7:0] NCP_OFS_STEP_UPPER = 8'h14;
  localparam logic [7:0] NCP_OFS_CTRL = 8'h18;
  localparam logic [7:0] NCP_OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] NCP_OFS_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] NCP_OFS_IRQ_ENABLE = 8'h24;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int NCP_CTRL_ENABLE_BIT = 0;
  localparam int NCP_IRQ_WRAP_BIT = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [19:0] NCP_ACC_RST = 20'h00000;
  localparam logic [19:0] NCP_STEP_RST = 20'h00001;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  // Oscillator edges from a low-byte write to the buffer load
  localparam logic [1:0] NCP_COMMIT_EDGES = 2'h2;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int NCP_HTRANS_ACTIVE_BIT = 1;

endpackage

/* rtl/ncp_edge_sync.sv */
// Purpose: Bring the oscillator input clock into the system clock domain
// Assumes: Oscillator input is well below half the system clock rate
// Notes:   Two flops resync the pin, a third one finds the rising edge

`timescale 1ns/1ps
`default_nettype none

module ncp_edge_sync
  import ncp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous pin
  input wire logic osc_input_clock,
  // One-cycle pulse per rising edge
  output logic osc_rise
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } ncp_sync_t;

  ncp_sync_t s_q;
  ncp_sync_t s_d;

  // Meta is read only by the sync stage, never by the edge logic
  always_comb begin
    s_d = s_q;
    s_d.meta = osc_input_clock;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  // Register the whole state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Rising edge of the resynchronised pin
  assign osc_rise = s_q.sync & ~s_q.last;

endmodule

`default_nettype wire

/* rtl/ncp_regs.sv */
// Purpose: Phase accumulator and double-buffered phase step of an oscillator
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Oscillator input is sampled on the system clock, so it must be
//          slower than half of it
//
// Overview of operation
// - Accumulator bits 7..0 form a read/write low byte register that resets to zero.
// - Accumulator bits 15..8 form a read/write high byte register that resets to zero.
// - Accumulator bits 19..16 sit in bits 3..0 of the upper register, bits 7..4 read zero.
// - Step bits 7..0 form a read/write low byte register whose reset value is one.
// - Step bits 15..8 form a read/write high byte register that resets to zero.
// - Step bits 19..16 sit in bits 3..0 of the upper step register, bits 7..4 read zero.
// - While enabled, each oscillator rising edge adds the buffered step to the 20-bit accumulator.
// - When enabled, a low step write loads the whole buffer on the second oscillator edge.
// - When disabled, a step write is copied into the buffer right away.
// - Every accumulator wrap sets a sticky flag that only software clears.
//
// The AHB-Lite register port and the address map are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module ncp_regs
  import ncp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Oscillator input pin
  input wire logic osc_input_clock,
  // Oscillator side
  output logic accum_wrap_event,
  output logic [19:0] phase_accum,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [19:0] accum;
    logic [19:0] step;
    logic [19:0] step_buf;
    logic enable;
    logic pend;
    logic [1:0] edge_cnt;
    logic irq_flag;
    logic irq_en;
    logic irq;
    logic wrap;
    logic ready;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
  } ncp_state_t;

  localparam ncp_state_t NCP_STATE_RST = '{
    accum: NCP_ACC_RST,
    step: NCP_STEP_RST,
    step_buf: NCP_STEP_RST,
    ready: 1'b1,
    default: '0
  };

  ncp_state_t s_q;
  ncp_state_t s_d;

  logic osc_rise;
  logic addr_take;
  logic wr_acc_low;
  logic wr_acc_high;
  logic wr_acc_upper;
  logic wr_step_low;
  logic wr_step_any;
  logic wr_clear;
  logic [20:0] sum;

  // ****************************************************************
  // Oscillator input resync
  // ****************************************************************
  ncp_edge_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .osc_input_clock(osc_input_clock),
    .osc_rise(osc_rise)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Address phase accepted; size is not checked, only words are used
  assign addr_take = hsel & htrans[NCP_HTRANS_ACTIVE_BIT] & hready;

  // Write strobes for the data phase now on the bus
  assign wr_acc_low = s_q.wr_pend & (s_q.wr_addr == NCP_OFS_ACC_LOW);
  assign wr_acc_high = s_q.wr_pend & (s_q.wr_addr == NCP_OFS_ACC_HIGH);
  assign wr_acc_upper = s_q.wr_pend & (s_q.wr_addr == NCP_OFS_ACC_UPPER);
  assign wr_step_low = s_q.wr_pend & (s_q.wr_addr == NCP_OFS_STEP_LOW);
  assign wr_step_any = wr_step_low
    | (s_q.wr_pend & (s_q.wr_addr == NCP_OFS_STEP_HIGH))
    | (s_q.wr_pend & (s_q.wr_addr == NCP_OFS_STEP_UPPER));
  assign wr_clear = s_q.wr_pend & (s_q.wr_addr == NCP_OFS_IRQ_CLEAR);

  // Adder with carry out, the carry is the wrap event
  assign sum = {1'b0, s_q.accum} + {1'b0, s_q.step_buf};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.wrap = 1'b0;
    s_d.ready = 1'b1;

    if (s_q.enable && osc_rise) begin
      s_d.accum = sum[19:0];
      s_d.wrap = sum[20];
    end

    if (wr_acc_low) begin
      s_d.accum[7:0] = hwdata[7:0];
    end
    if (wr_acc_high) begin
      s_d.accum[15:8] = hwdata[7:0];
    end
    if (wr_acc_upper) begin
      s_d.accum[19:16] = hwdata[3:0];
    end

    if (wr_step_low) begin
      s_d.step[7:0] = hwdata[7:0];
    end
    if (s_q.wr_pend && (s_q.wr_addr == NCP_OFS_STEP_HIGH)) begin
      s_d.step[15:8] = hwdata[7:0];
    end
    if (s_q.wr_pend && (s_q.wr_addr == NCP_OFS_STEP_UPPER)) begin
      s_d.step[19:16] = hwdata[3:0];
    end

    // Control register, enable steers the adder and the commit path
    if (s_q.wr_pend && (s_q.wr_addr == NCP_OFS_CTRL)) begin
      s_d.enable = hwdata[NCP_CTRL_ENABLE_BIT];
    end
    if (s_q.wr_pend && (s_q.wr_addr == NCP_OFS_IRQ_ENABLE)) begin
      s_d.irq_en = hwdata[NCP_IRQ_WRAP_BIT];
    end

    // count oscillator edges, load on the second
    if (s_q.pend && s_q.enable && osc_rise) begin
      s_d.edge_cnt = s_q.edge_cnt + 2'h1;
      if (s_q.edge_cnt + 2'h1 == NCP_COMMIT_EDGES) begin
        s_d.step_buf = s_q.step;
        s_d.pend = 1'b0;
        s_d.edge_cnt = 2'h0;
      end
    end
    // low byte write arms the commit
    if (wr_step_low && s_q.enable) begin
      s_d.pend = 1'b1;
      s_d.edge_cnt = 2'h0;
    end

    // disabled, copy straight into the buffer
    if (!s_d.enable) begin
      s_d.pend = 1'b0;
      s_d.edge_cnt = 2'h0;
      if (wr_step_any) begin
        s_d.step_buf = s_d.step;
      end
    end

    // sticky flag, a wrap beats a clear in the same cycle
    if (wr_clear && hwdata[NCP_IRQ_WRAP_BIT]) begin
      s_d.irq_flag = 1'b0;
    end
    if (s_d.wrap) begin
      s_d.irq_flag = 1'b1;
    end
    s_d.irq = s_d.irq_flag & s_d.irq_en;

    // Address phase capture; a write lands one cycle later
    s_d.wr_pend = addr_take & hwrite;
    s_d.wr_addr = haddr[NCP_AW-1:0];

    // reads see the value after this cycle's updates
    s_d.rdata = 32'h0000_0000;
    if (addr_take && !hwrite) begin
      case (haddr[NCP_AW-1:0])
        NCP_OFS_ACC_LOW: begin
          s_d.rdata = {24'h000000, s_d.accum[7:0]};
        end
        NCP_OFS_ACC_HIGH: begin
          s_d.rdata = {24'h000000, s_d.accum[15:8]};
        end
        NCP_OFS_ACC_UPPER: begin
          s_d.rdata = {28'h0000000, s_d.accum[19:16]};
        end
        NCP_OFS_STEP_LOW: begin
          s_d.rdata = {24'h000000, s_d.step[7:0]};
        end
        NCP_OFS_STEP_HIGH: begin
          s_d.rdata = {24'h000000, s_d.step[15:8]};
        end
        NCP_OFS_STEP_UPPER: begin
          s_d.rdata = {28'h0000000, s_d.step[19:16]};
        end
        NCP_OFS_CTRL: begin
          s_d.rdata = {31'h00000000, s_d.enable};
        end
        NCP_OFS_IRQ_STATUS: begin
          s_d.rdata = {31'h00000000, s_d.irq_flag};
        end
        NCP_OFS_IRQ_ENABLE: begin
          s_d.rdata = {31'h00000000, s_d.irq_en};
        end
        default: begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= NCP_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign hreadyout = s_q.ready;
  assign hresp = 1'b0 & s_q.ready;
  assign hrdata = s_q.rdata;
  assign accum_wrap_event = s_q.wrap;
  assign phase_accum = s_q.accum;
  assign irq = s_q.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_accum_advance: assert property (
    (s_q.enable && osc_rise && !s_q.wr_pend)
      |=> s_q.accum == 20'($past(s_q.accum) + $past(s_q.step_buf)))
    else $error("accumulator did not add the buffered step");

  a_accum_hold: assert property (
    (!osc_rise && !wr_acc_low && !wr_acc_high && !wr_acc_upper) |=> $stable(s_q.accum))
    else $error("accumulator changed without an edge or write");

  a_acc_low_write: assert property (
    wr_acc_low |=> s_q.accum[7:0] == $past(hwdata[7:0]))
    else $error("accumulator low byte write lost");

  a_acc_high_write: assert property (
    wr_acc_high |=> s_q.accum[15:8] == $past(hwdata[7:0]))
    else $error("accumulator high byte write lost");

  a_upper_read_zero: assert property (
    (addr_take && !hwrite && haddr[NCP_AW-1:0] == NCP_OFS_ACC_UPPER)
      |=> hrdata[31:4] == 28'h0000000 && hrdata[3:0] == s_q.accum[19:16])
    else $error("upper accumulator read wrong");

  a_step_low_reset: assert property (
    @(posedge clock) $rose(rst_n) |-> s_q.step == NCP_STEP_RST)
    else $error("step register reset value wrong");

  a_step_high_write: assert property (
    (s_q.wr_pend && s_q.wr_addr == NCP_OFS_STEP_HIGH) |=> s_q.step[15:8] == $past(hwdata[7:0]))
    else $error("step high byte write lost");

  a_step_upper_zero: assert property (
    (addr_take && !hwrite && haddr[NCP_AW-1:0] == NCP_OFS_STEP_UPPER)
      |=> hrdata[31:4] == 28'h0000000)
    else $error("upper step read not zero padded");

  // buffer loads on the second edge
  a_commit_second: assert property (
    (s_q.pend && s_q.enable && osc_rise && s_q.edge_cnt == 2'h1 && !wr_step_low)
      |=> s_q.step_buf == $past(s_q.step) && !s_q.pend)
    else $error("step buffer not loaded on second edge");

  a_copy_disabled: assert property (
    (wr_step_any && !s_q.enable && !(s_q.wr_addr == NCP_OFS_CTRL)) |=> s_q.step_buf == s_q.step)
    else $error("disabled step write not copied");

  a_flag_set: assert property (
    s_q.wrap |-> s_q.irq_flag ##1 (s_q.irq_flag || $past(wr_clear)))
    else $error("wrap flag not set or dropped");

  a_step_low_write: assert property (
    wr_step_low |=> s_q.step[7:0] == $past(hwdata[7:0]))
    else $error("step low byte write lost");

  // a stopped accumulator ignores the pin, only writes move it
  a_accum_stopped: assert property (
    (!s_q.enable && !wr_acc_low && !wr_acc_high && !wr_acc_upper) |=> $stable(s_q.accum))
    else $error("accumulator moved while stopped");

  // clearing the enable drops a pending commit
  a_disable_cancel: assert property (
    (s_q.wr_pend && s_q.wr_addr == NCP_OFS_CTRL && !hwdata[NCP_CTRL_ENABLE_BIT]) |=> !s_q.pend)
    else $error("pending commit survived a disable");

  // one wrap pulse per seen edge, never stretched
  a_wrap_one_cycle: assert property (
    s_q.wrap |=> !s_q.wrap)
    else $error("wrap pulse longer than one cycle");

  c_disabled_copy: cover property (wr_step_any && !s_q.enable);
  c_wrap_seen: cover property (s_q.wrap);
  c_commit_seen: cover property (s_q.pend ##[1:200] !s_q.pend && s_q.enable);
  c_irq_seen: cover property ($rose(irq));

endmodule

`default_nettype wire

/* dv/nco_phase_step_regs_test.sv */
// Purpose: Self-checking bench for the oscillator phase register bank
// Assumes: One AHB-Lite master, one zero-wait slave, oscillator pin driven here
// Notes:   An integer model follows every write and every oscillator edge

`timescale 1ns/1ps
`default_nettype none

module nco_phase_step_regs_test
  import ncp_pkg::*;
;
  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic clock, rst_n, hsel, hwrite, osc_input_clock;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, accum_wrap_event, irq;
  logic [19:0] phase_accum;
  logic [31:0] m_acc, m_step, m_buf, q;
  logic m_en, m_flag, m_ien;
  int m_pend, m_wraps, fails, check_count, i;
  int wraps_seen = 0;
  integer seed;

  // Single slave, so its ready is the bus ready
  ncp_regs dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .osc_input_clock(osc_input_clock), .accum_wrap_event(accum_wrap_event),
    .phase_accum(phase_accum), .irq(irq));

  // 25 MHz system clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Count one per cycle so a stretched pulse shows up as extra wraps
  always @(posedge clock) begin
    if (rst_n === 1'b1 && accum_wrap_event === 1'b1) wraps_seen <= wraps_seen + 1;
  end

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ****************************************************************
  // Bus master, every wait bounded
  // ****************************************************************
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      $display("wrong value hready expected 1 seen %b", hreadyout);
      wrap_up();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h00000000;
    wait_ready();
    q = hrdata;
  endtask

  // ****************************************************************
  // Register model
  // ****************************************************************
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      NCP_OFS_ACC_LOW: return m_acc & 32'h000000FF;
      NCP_OFS_ACC_HIGH: return (m_acc >> 8) & 32'h000000FF;
      NCP_OFS_ACC_UPPER: return (m_acc >> 16) & 32'h0000000F;
      NCP_OFS_STEP_LOW: return m_step & 32'h000000FF;
      NCP_OFS_STEP_HIGH: return (m_step >> 8) & 32'h000000FF;
      NCP_OFS_STEP_UPPER: return (m_step >> 16) & 32'h0000000F;
      NCP_OFS_CTRL: return {31'h00000000, m_en};
      NCP_OFS_IRQ_STATUS: return {31'h00000000, m_flag};
      NCP_OFS_IRQ_ENABLE: return {31'h00000000, m_ien};
      default: return 32'h00000000;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    case (a)
      NCP_OFS_ACC_LOW: m_acc = (m_acc & 32'h000FFF00) | (d & 32'h000000FF);
      NCP_OFS_ACC_HIGH: m_acc = (m_acc & 32'h000F00FF) | ((d & 32'h000000FF) << 8);
      NCP_OFS_ACC_UPPER: m_acc = (m_acc & 32'h0000FFFF) | ((d & 32'h0000000F) << 16);
      NCP_OFS_STEP_LOW: m_step = (m_step & 32'h000FFF00) | (d & 32'h000000FF);
      NCP_OFS_STEP_HIGH: m_step = (m_step & 32'h000F00FF) | ((d & 32'h000000FF) << 8);
      NCP_OFS_STEP_UPPER: m_step = (m_step & 32'h0000FFFF) | ((d & 32'h0000000F) << 16);
      NCP_OFS_CTRL: m_en = d[0];
      NCP_OFS_IRQ_CLEAR: if (d[0]) m_flag = 1'b0;
      NCP_OFS_IRQ_ENABLE: m_ien = d[0];
      default: ;
    endcase
    if (a == NCP_OFS_CTRL && !m_en) m_pend = 0;
    if (a >= NCP_OFS_STEP_LOW && a <= NCP_OFS_STEP_UPPER) begin
      if (!m_en) m_buf = m_step;
      else if (a == NCP_OFS_STEP_LOW) m_pend = 2;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h00000000);
    check($sformatf("register %h", a), q, exp_rd(a));
    check("hresp", {31'h00000000, hresp}, 32'h00000000);
  endtask

  // Pin stays high and low four clocks each, above the two-clock minimum
  task automatic osc_edge;
    logic [31:0] sum;
    @(posedge clock);
    osc_input_clock <= 1'b1;
    repeat (4) @(posedge clock);
    osc_input_clock <= 1'b0;
    repeat (4) @(posedge clock);
    if (m_en) begin
      // The loading edge still adds the old buffer contents
      sum = m_acc + m_buf;
      if (sum[20]) begin
        m_flag = 1'b1;
        m_wraps++;
      end
      m_acc = sum & 32'h000FFFFF;
      if (m_pend > 0) begin
        m_pend--;
        if (m_pend == 0) m_buf = m_step;
      end
    end
    check("phase_accum", {12'h000, phase_accum}, m_acc);
    check("irq", {31'h00000000, irq}, {31'h00000000, m_flag & m_ien});
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    m_acc = NCP_ACC_RST;
    m_step = NCP_STEP_RST;
    m_buf = NCP_STEP_RST;
    {m_en, m_flag, m_ien} = 3'h0;
    m_pend = 0;
  endtask

  task automatic reset_reads;
    for (int a = 0; a <= 40; a += 4) rd(8'(a));
    check("phase_accum", {12'h000, phase_accum}, m_acc);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_n, hsel, hwrite, osc_input_clock} = 4'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    {fails, check_count, m_wraps} = {3{32'h00000000}};
    seed = 32'h3AB6C3BD;
    do_reset();
    reset_reads();
    // Random bytes into every data register, upper nibbles must read zero
    for (i = 0; i < 6; i++) begin
      wr(8'(i * 4), $random(seed));
      rd(8'(i * 4));
    end
    wr(8'h28, $random(seed));
    wr(NCP_OFS_IRQ_STATUS, 32'hFFFFFFFF);
    rd(8'h28);
    rd(NCP_OFS_IRQ_STATUS);
    // Stopped: step writes go straight to the buffer
    wr(NCP_OFS_STEP_UPPER, 32'h00000000);
    wr(NCP_OFS_STEP_HIGH, $random(seed));
    wr(NCP_OFS_STEP_LOW, $random(seed));
    osc_edge();
    wr(NCP_OFS_CTRL, 32'h00000001);
    repeat (3) osc_edge();
    // Running: high and upper first, the step buffer holds until the low byte lands
    wr(NCP_OFS_STEP_UPPER, $random(seed));
    wr(NCP_OFS_STEP_HIGH, $random(seed));
    osc_edge();
    wr(NCP_OFS_STEP_LOW, $random(seed));
    repeat (3) osc_edge();
    // Accumulator bytes written while running
    for (i = 0; i < 3; i++) begin
      wr(8'(i * 4), $random(seed));
      rd(8'(i * 4));
    end
    check("phase_accum", {12'h000, phase_accum}, m_acc);
    osc_edge();
    // Arm a commit, then stop before the second edge so it is dropped
    wr(NCP_OFS_STEP_LOW, $random(seed));
    osc_edge();
    // Force a wrap, then mask, then clear
    wr(NCP_OFS_CTRL, 32'h00000000);
    wr(NCP_OFS_STEP_UPPER, 32'h00000000);
    wr(NCP_OFS_STEP_HIGH, 32'h00000001);
    wr(NCP_OFS_STEP_LOW, 32'h00000000);
    wr(NCP_OFS_CTRL, 32'h00000001);
    wr(NCP_OFS_IRQ_ENABLE, 32'h00000001);
    wr(NCP_OFS_ACC_UPPER, 32'h0000000F);
    wr(NCP_OFS_ACC_HIGH, 32'h000000FF);
    wr(NCP_OFS_ACC_LOW, 32'h00000080);
    osc_edge();
    check("wrap pulses", wraps_seen, m_wraps);
    rd(NCP_OFS_IRQ_STATUS);
    wr(NCP_OFS_IRQ_ENABLE, 32'h00000000);
    rd(NCP_OFS_IRQ_STATUS);
    check("irq", {31'h00000000, irq}, 32'h00000000);
    osc_edge();
    rd(NCP_OFS_IRQ_STATUS);
    wr(NCP_OFS_IRQ_CLEAR, 32'h00000001);
    wr(NCP_OFS_IRQ_ENABLE, 32'h00000001);
    rd(NCP_OFS_IRQ_STATUS);
    rd(NCP_OFS_IRQ_CLEAR);
    check("irq", {31'h00000000, irq}, 32'h00000000);
    check("wrap pulses", wraps_seen, m_wraps);
    // Second reset in mid-run
    do_reset();
    reset_reads();
    wrap_up();
  end

  // Run-time limit of 100000 clocks
  initial begin
    #4000000;
    fails++;
    $display("wrong value run time expected end seen limit");
    wrap_up();
  end

endmodule

`default_nettype wire
